// ---- core/pm_control_status_reg.sv ----
// power management control/status register with an AXI4-Lite slave
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps

// Behaviour
// - bits 1:0 hold the power state, read back as stored, 0 is D0, 3 is D3hot.
// - codes 1 and 2 (D1, D2) are reserved and never become the power state.
// - bit 3 reads one after reset, reporting context kept across D3hot to D0.
// - bit 8 set permits the port to send wake messages, clear forbids them.
// - bit 8 resets to zero only on fundamental reset, not on hot reset.
// - bit 15 is set by a port-originated wake event even with bit 8 clear, W1C.
// - wake messages merely forwarded by the bridge never set bit 15.
// - in the upstream port no wake is generated and bit 15 always reads zero.
// - data select, data scale and data fields read as zero.
// - bus power state support and bus power/clock control enable read zero.
module pm_control_status_reg
#(
  parameter bit UPSTREAM = 1'b0          // port is the upstream port
)
(
  input  wire logic        CORE_CLK,      // core clock, 20 MHz
  input  wire logic        RST_N,         // fundamental reset, sync, low
  input  wire logic        HOT_RST_N,     // hot reset, sync, low
  input  wire logic        LOAD_WAKE_EN,  // loader writes wake enable
  input  wire logic        LOAD_WAKE_VAL, // value from loader
  input  wire logic        PORT_WAKE,     // port originates a wake event
  input  wire logic        FWD_WAKE,      // bridge forwards a wake message
  output pm_csr_pkg::pm_state_type PM_STATE, // current register state
  output logic             WAKE_MSG_SEND, // send a wake message
  output logic             IRQ,           // level interrupt
  input  wire logic [11:0] S_AXI_AWADDR,  // write address
  input  wire logic        S_AXI_AWVALID, // write address valid
  output logic             S_AXI_AWREADY, // write address ready
  input  wire logic [31:0] S_AXI_WDATA,   // write data
  input  wire logic [3:0]  S_AXI_WSTRB,   // write strobes
  input  wire logic        S_AXI_WVALID,  // write data valid
  output logic             S_AXI_WREADY,  // write data ready
  output logic [1:0]       S_AXI_BRESP,   // write response
  output logic             S_AXI_BVALID,  // write response valid
  input  wire logic        S_AXI_BREADY,  // write response ready
  input  wire logic [11:0] S_AXI_ARADDR,  // read address
  input  wire logic        S_AXI_ARVALID, // read address valid
  output logic             S_AXI_ARREADY, // read address ready
  output logic [31:0]      S_AXI_RDATA,   // read data
  output logic [1:0]       S_AXI_RRESP,   // read response
  output logic             S_AXI_RVALID,  // read valid
  input  wire logic        S_AXI_RREADY   // read ready
);
  import pm_csr_pkg::*;

  // ==========================================================
  // write channel state
  logic        aw_held;
  logic        w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        bvalid;
  logic [1:0]  bresp;
  logic        next_aw_held;
  logic        next_w_held;
  logic [11:0] next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0]  next_w_strb;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        wr_fire;

  // accept each channel while it is not yet held and no response waits
  assign S_AXI_AWREADY = !aw_held && !bvalid;
  assign S_AXI_WREADY  = !w_held && !bvalid;
  assign wr_fire       = aw_held && w_held && !bvalid;

  // next values of the write channel
  always_comb
  begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    if (S_AXI_AWVALID && S_AXI_AWREADY)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY)
    begin
      next_w_held = 1'b1;
      next_w_data = S_AXI_WDATA;
      next_w_strb = S_AXI_WSTRB;
    end
    if (wr_fire)
    begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = (aw_addr == CSR_OFFSET || aw_addr == IRQ_STS_OFFSET
                      || aw_addr == IRQ_MSK_OFFSET) ? AXI_OKAY : AXI_SLVERR;
    end
    if (bvalid && S_AXI_BREADY)
      next_bvalid = 1'b0;
  end

  // register the write channel
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 12'h000;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= AXI_OKAY;
    end
    else
    begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
    end
  end

  assign S_AXI_BVALID = bvalid;
  assign S_AXI_BRESP  = bresp;

  // ==========================================================
  // register state
  logic [1:0] pwr_state;
  logic       keep_flag;
  logic       wake_en;
  logic       wake_evt;
  logic [1:0] irq_sts;
  logic [1:0] irq_msk;
  logic [1:0] next_pwr_state;
  logic       next_wake_en;
  logic       next_wake_evt;
  logic [1:0] next_irq_sts;
  logic [1:0] next_irq_msk;
  logic       wr_pm;
  logic       own_wake;
  logic       ps_changed;

  assign wr_pm    = wr_fire && aw_addr == CSR_OFFSET;
  // only the port's own event counts, never a forwarded one
  assign own_wake = PORT_WAKE && !UPSTREAM;

  // next values of the register fields
  always_comb
  begin
    next_pwr_state = pwr_state;
    next_wake_en  = wake_en;
    next_wake_evt = wake_evt;
    next_irq_msk  = irq_msk;
    ps_changed    = 1'b0;
    if (wr_pm && w_strb[0])
    begin
      // reserved codes leave the state alone
      if (w_data[1:0] == PWR_D0 || w_data[1:0] == PWR_D3HOT)
      begin
        next_pwr_state = w_data[1:0];
        ps_changed     = (w_data[1:0] != pwr_state);
      end
    end
    if (wr_pm && w_strb[1])
    begin
      next_wake_en = w_data[WAKE_EN_BIT];
      if (w_data[WAKE_EVT_BIT])
        next_wake_evt = 1'b0;
    end
    if (LOAD_WAKE_EN)
      next_wake_en = LOAD_WAKE_VAL;
    // set wins over a clearing write in the same cycle
    if (own_wake)
      next_wake_evt = 1'b1;
    if (UPSTREAM)
      next_wake_evt = 1'b0;
    if (wr_fire && aw_addr == IRQ_MSK_OFFSET && w_strb[0])
      next_irq_msk = w_data[1:0];
    next_irq_sts = irq_sts;
    if (wr_fire && aw_addr == IRQ_STS_OFFSET && w_strb[0])
      next_irq_sts = irq_sts & ~w_data[1:0];
    if (ps_changed)
      next_irq_sts[IRQ_PWR_BIT] = 1'b1;
    if (own_wake)
      next_irq_sts[IRQ_WAKE_BIT] = 1'b1;
  end

  // hot reset returns the power state only; sticky bits survive it
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      pwr_state <= PWR_RESET;
      keep_flag <= KEEP_RESET;
      wake_en   <= WAKE_EN_RESET;
      wake_evt  <= WAKE_EV_RESET;
      irq_sts   <= IRQ_RESET;
      irq_msk   <= IRQ_RESET;
    end
    else
    begin
      pwr_state <= HOT_RST_N ? next_pwr_state : PWR_RESET;
      keep_flag <= KEEP_RESET;
      wake_en   <= next_wake_en;
      wake_evt  <= next_wake_evt;
      irq_sts   <= next_irq_sts;
      irq_msk   <= next_irq_msk;
    end
  end

  assign PM_STATE      = '{pwr_state, keep_flag, wake_en, wake_evt};
  assign WAKE_MSG_SEND = own_wake && wake_en;
  assign IRQ           = |(irq_sts & irq_msk);

  // ==========================================================
  // read channel
  logic        rvalid;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic [31:0] pm_word;

  // unimplemented fields are constant zero
  always_comb
  begin
    pm_word = 32'h0000_0000;
    pm_word[PWR_LSB +: 2]     = pwr_state;
    pm_word[KEEP_BIT]         = keep_flag;
    pm_word[WAKE_EN_BIT]      = wake_en;
    pm_word[WAKE_EVT_BIT]     = wake_evt;
  end

  assign S_AXI_ARREADY = !rvalid;

  // next values of the read channel
  always_comb
  begin
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (S_AXI_ARVALID && !rvalid)
    begin
      next_rvalid = 1'b1;
      next_rresp  = AXI_OKAY;
      case (S_AXI_ARADDR)
        CSR_OFFSET:     next_rdata = pm_word;
        IRQ_STS_OFFSET: next_rdata = {30'h0000_0000, irq_sts};
        IRQ_MSK_OFFSET: next_rdata = {30'h0000_0000, irq_msk};
        default:
        begin
          next_rdata = 32'h0000_0000;
          next_rresp = AXI_SLVERR;
        end
      endcase
    end
    else if (rvalid && S_AXI_RREADY)
      next_rvalid = 1'b0;
  end

  // register the read channel
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= AXI_OKAY;
    end
    else
    begin
      rvalid <= next_rvalid;
      rdata  <= next_rdata;
      rresp  <= next_rresp;
    end
  end

  assign S_AXI_RVALID = rvalid;
  assign S_AXI_RDATA  = rdata;
  assign S_AXI_RRESP  = rresp;

  // ==========================================================
  // assertions
  a_power_state_field_legal: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    pwr_state != PWR_D1 && pwr_state != PWR_D2)
    else $error("power state holds a reserved code");
  a_reserved_kept: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (wr_pm && w_strb[0] && w_data[1] != w_data[0] && HOT_RST_N)
      |=> pwr_state == $past(pwr_state))
    else $error("reserved code changed the power state");
  a_power_state_field_write: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (wr_pm && w_strb[0] && w_data[1] == w_data[0] && HOT_RST_N)
      |=> pwr_state == $past(w_data[1:0]))
    else $error("legal power state write lost");
  a_keep_one: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    pm_word[KEEP_BIT])
    else $error("context keep flag not one");
  a_wake_gate: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    WAKE_MSG_SEND == (PORT_WAKE && !UPSTREAM && wake_en))
    else $error("wake message not gated by enable");
  a_hot_sticky: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (!HOT_RST_N && !wr_pm && !LOAD_WAKE_EN) |=> $stable(wake_en))
    else $error("hot reset disturbed wake enable");
  a_event_sets: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (PORT_WAKE && !UPSTREAM) |=> wake_evt)
    else $error("own wake event did not set status");
  a_fwd_no_set: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (FWD_WAKE && !PORT_WAKE && !wake_evt) |=> !wake_evt)
    else $error("forwarded wake set status");
  a_upstream_zero: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    UPSTREAM |-> !wake_evt)
    else $error("upstream port shows wake status");
  a_zero_fields: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (pm_word & 32'hFFFF_7EF4) == 32'h0000_0000)
    else $error("unimplemented field not zero");

  c_d3_entry:  cover property (@(posedge CORE_CLK) disable iff (!RST_N)
    wr_pm ##1 pwr_state == PWR_D3HOT);
  c_wake_sent: cover property (@(posedge CORE_CLK) disable iff (!RST_N)
    WAKE_MSG_SEND);
  c_irq_high:  cover property (@(posedge CORE_CLK) disable iff (!RST_N)
    IRQ);

endmodule

// ---- core/pm_csr_pkg.sv ----
// package: register map, field positions, reset values and carrier type
package pm_csr_pkg;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [11:0] CSR_OFFSET     = 12'h0C4;
  localparam logic [11:0] IRQ_STS_OFFSET = 12'h0C8;
  localparam logic [11:0] IRQ_MSK_OFFSET = 12'h0CC;

  // ==========================================================
  // field positions inside the control/status word
  localparam int PWR_LSB      = 0;
  localparam int KEEP_BIT     = 3;
  localparam int WAKE_EN_BIT  = 8;
  localparam int WAKE_EVT_BIT = 15;

  // ==========================================================
  // power state codes and reset values
  localparam logic [1:0] PWR_D0        = 2'h0;
  localparam logic [1:0] PWR_D1        = 2'h1;
  localparam logic [1:0] PWR_D2        = 2'h2;
  localparam logic [1:0] PWR_D3HOT     = 2'h3;
  localparam logic [1:0] PWR_RESET     = 2'h0;
  localparam logic       KEEP_RESET    = 1'h1;
  localparam logic       WAKE_EN_RESET = 1'h0;
  localparam logic       WAKE_EV_RESET = 1'h0;
  localparam logic [1:0] IRQ_RESET     = 2'h0;
  localparam logic [1:0] AXI_OKAY      = 2'h0;
  localparam logic [1:0] AXI_SLVERR    = 2'h2;

  // interrupt status bits: 0 power state changed, 1 wake event
  localparam int IRQ_PWR_BIT    = 0;
  localparam int IRQ_WAKE_BIT   = 1;

  // ==========================================================
  // carrier: the block's visible power state
  typedef struct packed {
    logic [1:0] power_state_field;
    logic       context_keep_flag;
    logic       wake_msg_enable;
    logic       wake_event_flag;
  } pm_state_type;

endpackage

// ---- bench/pm_control_status_reg_tb.sv ----
// self-checking bench for the power management control/status register
`timescale 1ns/1ps
module pm_control_status_reg_tb;
  import pm_csr_pkg::*;
  logic         clk = 1'h0;
  logic         rst_n = 1'h0;
  logic         hot_n = 1'h1;
  logic         ld_en = 1'h0;
  logic         ld_val = 1'h0;
  logic         pwake = 1'h0;
  logic         fwake = 1'h0;
  logic         send, irq, awready, wready, bvalid, arready, rvalid;
  pm_state_type st;
  pm_state_type st_up;
  logic         send_up;
  logic [11:0]  awaddr = 12'h0;
  logic [11:0]  araddr = 12'h0;
  logic [31:0]  wdata = 32'h0;
  logic [31:0]  rdata, d;
  logic         awvalid = 1'h0;
  logic         wvalid = 1'h0;
  logic         bready = 1'h0;
  logic         arvalid = 1'h0;
  logic         rready = 1'h0;
  logic [1:0]   bresp, rresp, r;
  logic [1:0]   e_ps = PWR_RESET;
  logic         e_en = 1'h0;
  logic         e_ev = 1'h0;
  int           err_count = 0;
  int           n_checks = 0;
  integer       seed = 32'h6B2D4F9A;

  pm_control_status_reg dut (.CORE_CLK(clk), .RST_N(rst_n), .HOT_RST_N(hot_n),
    .LOAD_WAKE_EN(ld_en), .LOAD_WAKE_VAL(ld_val), .PORT_WAKE(pwake),
    .FWD_WAKE(fwake), .PM_STATE(st), .WAKE_MSG_SEND(send), .IRQ(irq),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

  // upstream port copy: same stimulus, wake status must stay zero
  pm_control_status_reg #(.UPSTREAM(1'b1)) dut_up (.CORE_CLK(clk),
    .RST_N(rst_n), .HOT_RST_N(hot_n), .LOAD_WAKE_EN(ld_en),
    .LOAD_WAKE_VAL(ld_val), .PORT_WAKE(pwake), .FWD_WAKE(fwake),
    .PM_STATE(st_up), .WAKE_MSG_SEND(send_up), .IRQ(),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(), .S_AXI_BRESP(), .S_AXI_BVALID(),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(), .S_AXI_RDATA(), .S_AXI_RRESP(),
    .S_AXI_RVALID(), .S_AXI_RREADY(rready));

  // ==========================================================
  // clock and checking helpers
  initial
  forever #25 clk = ~clk;

  // expected register word from the bench model
  function automatic logic [31:0] exp_csr();
    return {16'h0, e_ev, 6'h0, e_en, 4'h0, 1'h1, 1'h0, e_ps};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ==========================================================
  // bus tasks: hold each channel until its ready is seen
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    int t;
    t = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge clk);
      t++;
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end
    while (!bvalid && t < 50);
    if (t >= 50) err_count++;
    r = bresp;
    bready <= 1'h0;
  endtask

  task automatic rd(input logic [11:0] a);
    int t;
    t = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge clk);
      t++;
      if (arready) arvalid <= 1'h0;
    end
    while (!rvalid && t < 50);
    if (t >= 50) err_count++;
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask

  task automatic wr_ok(input logic [11:0] a, input logic [31:0] v);
    wr(a, v);
    chk({30'h0, r}, {30'h0, AXI_OKAY});
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e,
                        input logic [1:0] er);
    rd(a);
    chk(d, e);
    chk({30'h0, r}, {30'h0, er});
  endtask

  // register word and visible state against the model
  task automatic csr_chk();
    rd_chk(CSR_OFFSET, exp_csr(), AXI_OKAY);
    chk({27'h0, st}, {27'h0, e_ps, 1'h1, e_en, e_ev});
  endtask

  task automatic irq_chk(input logic e);
    @(negedge clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask

  // one-cycle wake event, own or forwarded
  task automatic wake(input logic own);
    @(posedge clk);
    pwake <= own;
    fwake <= !own;
    @(negedge clk);
    chk({31'h0, send}, {31'h0, own & e_en});
    chk({31'h0, send_up}, 32'h0);
    @(posedge clk);
    pwake <= 1'h0;
    fwake <= 1'h0;
    e_ev = e_ev | own;
    @(negedge clk);
    chk({31'h0, st_up.wake_event_flag}, 32'h0);
  endtask

  // ==========================================================
  // watchdog
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    print_verdict();
  end

  // ==========================================================
  // test sequence
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    csr_chk();
    $display("test reset values done");
    for (int c = 3; c >= 0; c--)
    begin
      wr_ok(CSR_OFFSET, {16'hFFFF, 14'h1EFF, 2'(c)});
      if (c == 0 || c == 3) e_ps = 2'(c);
      e_en = 1'h1;
      csr_chk();
    end
    for (int i = 0; i < 16; i++)
    begin
      d = $random(seed);
      d[3] = 1'h1;
      wr_ok(CSR_OFFSET, d);
      if (d[1:0] == PWR_D0 || d[1:0] == PWR_D3HOT) e_ps = d[1:0];
      e_en = d[8];
      csr_chk();
    end
    $display("test power state writes done");
    wr_ok(CSR_OFFSET, 32'h0);
    e_ps = PWR_D0;
    e_en = 1'h0;
    wr_ok(IRQ_STS_OFFSET, 32'h3);
    wr_ok(IRQ_MSK_OFFSET, 32'h2);
    rd_chk(IRQ_STS_OFFSET, 32'h0, AXI_OKAY);
    wake(1'h0);
    csr_chk();
    irq_chk(1'h0);
    wake(1'h1);
    csr_chk();
    irq_chk(1'h1);
    rd_chk(IRQ_STS_OFFSET, 32'h2, AXI_OKAY);
    wr_ok(IRQ_MSK_OFFSET, 32'h0);
    irq_chk(1'h0);
    wr_ok(IRQ_MSK_OFFSET, 32'h2);
    irq_chk(1'h1);
    wr_ok(CSR_OFFSET, 32'h103);
    e_ps = PWR_D3HOT;
    e_en = 1'h1;
    wake(1'h1);
    wr_ok(CSR_OFFSET, 32'h8103);
    e_ev = 1'h0;
    csr_chk();
    wr_ok(IRQ_STS_OFFSET, 32'h3);
    irq_chk(1'h0);
    $display("test wake events done");
    @(posedge clk);
    hot_n <= 1'h0;
    repeat (2) @(posedge clk);
    hot_n <= 1'h1;
    e_ps = PWR_D0;
    csr_chk();
    @(posedge clk);
    ld_en <= 1'h1;
    @(posedge clk);
    ld_en <= 1'h0;
    e_en = 1'h0;
    csr_chk();
    ld_val <= 1'h1;
    ld_en <= 1'h1;
    @(posedge clk);
    ld_en <= 1'h0;
    e_en = 1'h1;
    csr_chk();
    $display("test hot reset and loader done");
    wr(12'h100, 32'hFFFF_FFFF);
    chk({30'h0, r}, {30'h0, AXI_SLVERR});
    rd_chk(12'h100, 32'h0, AXI_SLVERR);
    $display("test unmapped access done");
    wake(1'h1);
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    e_en = WAKE_EN_RESET;
    e_ev = WAKE_EV_RESET;
    csr_chk();
    irq_chk(1'h0);
    $display("test fundamental reset done");
    print_verdict();
  end
endmodule
